// ==== shared/cs_pkg.sv ====
// constants, types and tables shared by the cyclic sense timer ends
package cs_pkg;
	localparam int CLK_PERIOD_NS = 20;
	localparam int TICK_NS = 1000;
	localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FILTER_US = 16;
	localparam int FILTER_TICKS = (FILTER_US * 1000 + TICK_NS - 1) / TICK_NS;
	localparam int RESTART_US = 100;
	localparam int RESTART_TICKS = (RESTART_US * 1000 + TICK_NS - 1) / TICK_NS;
	localparam int NUM_WAKE = 3;
	localparam int NUM_HS = 3;
	localparam int CNT_W = 22;
	typedef logic [CNT_W-1:0] cnt_t;
	// period and on-time figures in microseconds
	localparam int PER_10MS_US = 10000;
	localparam int PER_20MS_US = 20000;
	localparam int PER_50MS_US = 50000;
	localparam int PER_100MS_US = 100000;
	localparam int PER_200MS_US = 200000;
	localparam int PER_1S_US = 1000000;
	localparam int PER_2S_US = 2000000;
	localparam int ON_0P1MS_US = 100;
	localparam int ON_0P3MS_US = 300;
	localparam int ON_1MS_US = 1000;
	localparam int ON_10MS_US = 10000;
	localparam int ON_20MS_US = 20000;
	localparam logic [2:0] ON_OFF_LOW = 3'h0;
	localparam logic [2:0] ON_OFF_HIGH = 3'h6;
	// device register indices on the link
	localparam logic [3:0] REG_TIMER1 = 4'h0;
	localparam logic [3:0] REG_TIMER2 = 4'h1;
	localparam logic [3:0] REG_HS1 = 4'h2;
	localparam logic [3:0] REG_HS2 = 4'h3;
	localparam logic [3:0] REG_WK_CTRL = 4'h4;
	localparam logic [3:0] REG_WK_STAT1 = 4'h5;
	localparam logic [3:0] REG_WK_STAT2 = 4'h6;
	localparam logic [3:0] REG_WK_LVL = 4'h7;
	localparam logic [3:0] REG_MODE = 4'h8;
	localparam logic [3:0] REG_FAIL = 4'h9;
	localparam int TMR_PER_LSB = 0;
	localparam int TMR_ON_LSB = 4;
	localparam int HS_A_LSB = 0;
	localparam int HS_B_LSB = 4;
	localparam int WKC_TSRC_LSB = 0;
	localparam int WKC_CYC_LSB = 2;
	localparam int WKC_TSEL_LSB = 5;
	localparam logic [7:0] REG_RESET = 8'h00;
	// host APB offsets and fields
	localparam logic [7:0] APB_CMD = 8'h00;
	localparam logic [7:0] APB_STAT = 8'h04;
	localparam int CMD_ADDR_LSB = 0;
	localparam int CMD_DATA_LSB = 8;
	localparam int CMD_WE_BIT = 16;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_INT_BIT = 1;
	localparam int STAT_DATA_LSB = 8;
	typedef enum logic [2:0] {
		MODE_NORMAL = 3'b000,
		MODE_STOP = 3'b001,
		MODE_SLEEP = 3'b010,
		MODE_RESTART = 3'b011,
		MODE_FAILSAFE = 3'b100
	} mode_t;
	function automatic cnt_t period_ticks(input logic [2:0] s);
		int us;
		case (s)
			3'h1: us = PER_20MS_US;
			3'h2: us = PER_50MS_US;
			3'h3: us = PER_100MS_US;
			3'h4: us = PER_200MS_US;
			3'h5: us = PER_1S_US;
			3'h6: us = PER_2S_US;
			default: us = PER_10MS_US;
		endcase
		return CNT_W'(us * 1000 / TICK_NS);
	endfunction
	function automatic cnt_t on_ticks(input logic [2:0] s);
		int us;
		case (s)
			3'h1: us = ON_0P1MS_US;
			3'h2: us = ON_0P3MS_US;
			3'h3: us = ON_1MS_US;
			3'h4: us = ON_10MS_US;
			3'h5: us = ON_20MS_US;
			default: us = 0;
		endcase
		return CNT_W'(us * 1000 / TICK_NS);
	endfunction
	function automatic logic on_running(input logic [2:0] s);
		return (s >= 3'h1) && (s <= 3'h5);
	endfunction
endpackage

// ==== shared/cs_link_if.sv ====
// register link between the controller end and the device end
`timescale 1ns/10ps
interface cs_link_if;
	logic req;
	logic we;
	logic [3:0] addr;
	logic [7:0] wdata;
	logic ack;
	logic [7:0] rdata;
	logic int_n;
	modport dev(input req, input we, input addr, input wdata,
		output ack, output rdata, output int_n);
	modport host(output req, output we, output addr, output wdata,
		input ack, input rdata, input int_n);
endinterface

// ==== hw/cs_timer.sv ====
// one cyclic timer: period, on-time window and its edge pulses
`timescale 1ns/10ps
module cs_timer (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_tick,
	input wire logic i_restart,
	input wire logic [2:0] i_period_sel,
	input wire logic [2:0] i_on_sel,
	output logic o_level,
	output logic o_start,
	output logic o_on_end
);
	cs_pkg::cnt_t cnt_q;
	cs_pkg::cnt_t per;
	cs_pkg::cnt_t onl;
	logic first_q;
	logic run;

	assign per = cs_pkg::period_ticks(i_period_sel);
	assign onl = cs_pkg::on_ticks(i_on_sel);
	assign run = cs_pkg::on_running(i_on_sel);
	// the very first on-time after a start gives no start pulse; its end still pulses
	assign o_start = i_tick && run && (cnt_q == '0) && !first_q;
	assign o_on_end = i_tick && run && (cnt_q == onl - 1'b1);

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			cnt_q <= '0;
		end else if (i_restart) begin
			cnt_q <= '0;
		end else if (i_tick && run) begin
			cnt_q <= (cnt_q >= per - 1'b1) ? '0 : cnt_q + 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			first_q <= 1'b1;
		end else if (i_restart) begin
			first_q <= 1'b1;
		end else if (i_tick && run && cnt_q == '0) begin
			first_q <= 1'b0;
		end
	end

	// off settings pin the level so a start causes no false edge
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_level <= 1'b0;
		end else begin
			o_level <= (i_on_sel == cs_pkg::ON_OFF_HIGH) || (run && cnt_q < onl);
		end
	end
endmodule

// ==== hw/cs_device.sv ====
// device end: timers, wake filters, wake flags, switch drive and modes
`timescale 1ns/10ps
module cs_device #(
	parameter int TICK_CYCLES = cs_pkg::TICK_CYCLES
) (
	input wire logic I_MCLK,
	input wire logic I_RST_N,
	input wire logic [2:0] I_WAKE_IN,
	input wire logic [2:0] I_HS_FAULT,
	input wire logic I_FAIL_SAFE,
	output logic [2:0] O_HS_ON,
	output logic O_MAIN_SUPPLY_EN,
	output logic O_RESET_N,
	output logic [2:0] O_MODE,
	cs_link_if.dev link
);
	if (TICK_CYCLES < 1 || TICK_CYCLES > 65535) begin : g_bad_tick
		$error("tick divider out of range");
	end
	if (cs_pkg::FILTER_TICKS < 1 || cs_pkg::FILTER_TICKS > 32) begin : g_bad_filt
		$error("filter count out of range");
	end

	logic [15:0] pre_q;
	logic tick;
	logic wr;
	logic [7:0] t1_q;
	logic [7:0] t2_q;
	logic [7:0] hs1_q;
	logic [7:0] hs2_q;
	logic [7:0] wkc_q;
	logic [7:0] st1_q;
	logic [7:0] st2_q;
	logic [2:0] lvl_q;
	logic fail_q;
	logic [15:0] rcnt_q;
	cs_pkg::mode_t mode_q;
	logic ns;
	logic [1:0] rst_t;
	logic [1:0] tl;
	logic [1:0] ts;
	logic [1:0] te;
	logic [1:0] tw;
	logic [2:0] evt;
	logic [2:0] dn;
	logic [2:0] smp;
	logic [2:0] cyc_v;
	logic [2:0] flt_q;
	logic [2:0][1:0] hs_sel;
	logic [2:0] hs_clr;
	logic pend;
	logic [7:0] rd;
	logic [2:0] on_w;
	logic [2:0] per_w;

	// microsecond time base for every count in the block
	assign tick = (pre_q == 16'(TICK_CYCLES - 1));
	always_ff @(posedge I_MCLK) begin
		if (!I_RST_N || tick) begin
			pre_q <= 16'h0000;
		end else begin
			pre_q <= pre_q + 16'h0001;
		end
	end

	assign wr = link.req && link.we;
	assign ns = (mode_q == cs_pkg::MODE_NORMAL) || (mode_q == cs_pkg::MODE_STOP);

	always_ff @(posedge I_MCLK) begin
		if (!I_RST_N) begin
			t1_q <= cs_pkg::REG_RESET;
			t2_q <= cs_pkg::REG_RESET;
			hs1_q <= cs_pkg::REG_RESET;
			hs2_q <= cs_pkg::REG_RESET;
			wkc_q <= cs_pkg::REG_RESET;
		end else if (wr) begin
			if (link.addr == cs_pkg::REG_TIMER1) begin
				t1_q <= link.wdata;
			end else if (link.addr == cs_pkg::REG_TIMER2) begin
				t2_q <= link.wdata;
			end else if (link.addr == cs_pkg::REG_HS1) begin
				hs1_q <= link.wdata;
			end else if (link.addr == cs_pkg::REG_HS2) begin
				hs2_q <= link.wdata;
			end else if (link.addr == cs_pkg::REG_WK_CTRL) begin
				wkc_q <= link.wdata;
			end
		end
	end

	// writing a timer control restarts it at once
	assign rst_t[0] = wr && (link.addr == cs_pkg::REG_TIMER1);
	assign rst_t[1] = wr && (link.addr == cs_pkg::REG_TIMER2);

	cs_timer u_timer1 (
		.i_clk(I_MCLK),
		.i_rst_n(I_RST_N),
		.i_tick(tick),
		.i_restart(rst_t[0]),
		.i_period_sel(t1_q[cs_pkg::TMR_PER_LSB +: 3]),
		.i_on_sel(t1_q[cs_pkg::TMR_ON_LSB +: 3]),
		.o_level(tl[0]),
		.o_start(ts[0]),
		.o_on_end(te[0])
	);

	cs_timer u_timer2 (
		.i_clk(I_MCLK),
		.i_rst_n(I_RST_N),
		.i_tick(tick),
		.i_restart(rst_t[1]),
		.i_period_sel(t2_q[cs_pkg::TMR_PER_LSB +: 3]),
		.i_on_sel(t2_q[cs_pkg::TMR_ON_LSB +: 3]),
		.o_level(tl[1]),
		.o_start(ts[1]),
		.o_on_end(te[1])
	);

	for (genvar i = 0; i < cs_pkg::NUM_WAKE; i++) begin : g_wk
		logic busy_q;
		logic cap_q;
		logic ref_q;
		logic refv_q;
		logic [4:0] fcnt_q;
		logic tsel;
		logic start;
		logic done;
		assign tsel = wkc_q[cs_pkg::WKC_TSEL_LSB + i];
		assign cyc_v[i] = wkc_q[cs_pkg::WKC_CYC_LSB + i] && mode_q != cs_pkg::MODE_FAILSAFE;
		assign start = cyc_v[i] ? te[tsel] : (I_WAKE_IN[i] != ref_q);
		assign done = busy_q && tick && (I_WAKE_IN[i] == cap_q)
			&& (fcnt_q == 5'(cs_pkg::FILTER_TICKS - 1));
		// first cyclic sample only becomes the reference
		assign evt[i] = done && (cap_q != ref_q) && (refv_q || !cyc_v[i]);
		assign dn[i] = done;
		assign smp[i] = cap_q;
		always_ff @(posedge I_MCLK) begin
			if (!I_RST_N) begin
				busy_q <= 1'b0;
				cap_q <= 1'b0;
				ref_q <= 1'b0;
				refv_q <= 1'b0;
				fcnt_q <= 5'h00;
			end else if (cyc_v[i] && rst_t[tsel]) begin
				busy_q <= 1'b0;
				refv_q <= 1'b0;
			end else if (!busy_q && start) begin
				busy_q <= 1'b1;
				cap_q <= I_WAKE_IN[i];
				fcnt_q <= 5'h00;
			end else if (busy_q && I_WAKE_IN[i] != cap_q) begin
				busy_q <= 1'b0;
			end else if (done) begin
				busy_q <= 1'b0;
				ref_q <= cap_q;
				refv_q <= cyc_v[i];
			end else if (busy_q && tick) begin
				fcnt_q <= fcnt_q + 5'h01;
			end
		end
	end

	assign tw = ts & wkc_q[cs_pkg::WKC_TSRC_LSB +: 2] & {2{ns}};

	// flags: a set in the clearing cycle survives
	always_ff @(posedge I_MCLK) begin
		if (!I_RST_N) begin
			st1_q <= cs_pkg::REG_RESET;
			st2_q <= cs_pkg::REG_RESET;
			fail_q <= 1'b0;
		end else begin
			st1_q <= (st1_q & ~((wr && link.addr == cs_pkg::REG_WK_STAT1) ? link.wdata : 8'h00))
				| {5'h00, evt};
			st2_q <= (st2_q & ~((wr && link.addr == cs_pkg::REG_WK_STAT2) ? link.wdata : 8'h00))
				| {6'h00, tw};
			fail_q <= (fail_q && !(wr && link.addr == cs_pkg::REG_FAIL && link.wdata[0]))
				|| ((rst_t[0] || rst_t[1]) && cs_pkg::on_running(on_w)
				&& cs_pkg::on_ticks(on_w) > cs_pkg::period_ticks(per_w));
		end
	end
	assign on_w = link.wdata[cs_pkg::TMR_ON_LSB +: 3];
	assign per_w = link.wdata[cs_pkg::TMR_PER_LSB +: 3];

	always_ff @(posedge I_MCLK) begin
		if (!I_RST_N) begin
			lvl_q <= 3'h0;
		end else if (ns) begin
			for (int i = 0; i < cs_pkg::NUM_WAKE; i++) begin
				lvl_q[i] <= cyc_v[i] ? (dn[i] ? smp[i] : lvl_q[i]) : I_WAKE_IN[i];
			end
		end
	end

	// any wake flag still pending turns a sleep request into a restart; the fail flag does not
	assign pend = (|st1_q) || (|st2_q) || (|evt) || (|tw);

	always_ff @(posedge I_MCLK) begin
		if (!I_RST_N) begin
			mode_q <= cs_pkg::MODE_NORMAL;
		end else if (I_FAIL_SAFE && mode_q != cs_pkg::MODE_FAILSAFE) begin
			mode_q <= cs_pkg::MODE_FAILSAFE;
		end else begin
			case (mode_q)
				cs_pkg::MODE_NORMAL, cs_pkg::MODE_STOP: begin
					if (wr && link.addr == cs_pkg::REG_MODE) begin
						if (link.wdata[2:0] == cs_pkg::MODE_SLEEP) begin
							mode_q <= pend ? cs_pkg::MODE_RESTART : cs_pkg::MODE_SLEEP;
						end else if (link.wdata[2:0] == cs_pkg::MODE_STOP) begin
							mode_q <= cs_pkg::MODE_STOP;
						end else if (link.wdata[2:0] == cs_pkg::MODE_NORMAL) begin
							mode_q <= cs_pkg::MODE_NORMAL;
						end
					end
				end
				cs_pkg::MODE_SLEEP: begin
					if (|evt) begin
						mode_q <= cs_pkg::MODE_RESTART;
					end
				end
				cs_pkg::MODE_RESTART: begin
					if (tick && rcnt_q == 16'(cs_pkg::RESTART_TICKS - 1)) begin
						mode_q <= cs_pkg::MODE_NORMAL;
					end
				end
				cs_pkg::MODE_FAILSAFE: begin
					if (!I_FAIL_SAFE && (|evt)) begin
						mode_q <= cs_pkg::MODE_RESTART;
					end
				end
				default: begin
					mode_q <= cs_pkg::MODE_NORMAL;
				end
			endcase
		end
	end

	always_ff @(posedge I_MCLK) begin
		if (!I_RST_N || mode_q != cs_pkg::MODE_RESTART) begin
			rcnt_q <= 16'h0000;
		end else if (tick) begin
			rcnt_q <= rcnt_q + 16'h0001;
		end
	end

	always_ff @(posedge I_MCLK) begin
		if (!I_RST_N) begin
			O_RESET_N <= 1'b0;
			O_MAIN_SUPPLY_EN <= 1'b0;
			O_MODE <= cs_pkg::MODE_NORMAL;
			link.int_n <= 1'b1;
		end else begin
			O_RESET_N <= mode_q != cs_pkg::MODE_RESTART;
			O_MAIN_SUPPLY_EN <= ns || mode_q == cs_pkg::MODE_RESTART;
			O_MODE <= mode_q;
			link.int_n <= !(ns && ((|st1_q) || (|st2_q)));
		end
	end

	// switch mapping: 0 off, 1 timer one, 2 timer two, 3 on
	assign hs_sel[0] = hs1_q[cs_pkg::HS_A_LSB +: 2];
	assign hs_sel[1] = hs1_q[cs_pkg::HS_B_LSB +: 2];
	assign hs_sel[2] = hs2_q[cs_pkg::HS_A_LSB +: 2];
	assign hs_clr[0] = wr && link.addr == cs_pkg::REG_HS1;
	assign hs_clr[1] = hs_clr[0];
	assign hs_clr[2] = wr && link.addr == cs_pkg::REG_HS2;

	// a switch faulted in normal, stop or sleep stays off until its control is rewritten;
	// the timer is left running, so wake samples may be lost
	always_ff @(posedge I_MCLK) begin
		if (!I_RST_N) begin
			flt_q <= 3'h0;
			O_HS_ON <= 3'h0;
		end else begin
			for (int i = 0; i < cs_pkg::NUM_HS; i++) begin
				flt_q[i] <= (flt_q[i] && !hs_clr[i])
					|| (I_HS_FAULT[i] && (ns || mode_q == cs_pkg::MODE_SLEEP));
				O_HS_ON[i] <= mode_q != cs_pkg::MODE_FAILSAFE && !flt_q[i] && !I_HS_FAULT[i]
					&& ((hs_sel[i] == 2'h1 && tl[0]) || (hs_sel[i] == 2'h2 && tl[1])
					|| hs_sel[i] == 2'h3);
			end
		end
	end

	always_comb begin
		if (link.addr == cs_pkg::REG_TIMER1) begin
			rd = t1_q;
		end else if (link.addr == cs_pkg::REG_TIMER2) begin
			rd = t2_q;
		end else if (link.addr == cs_pkg::REG_HS1) begin
			rd = hs1_q;
		end else if (link.addr == cs_pkg::REG_HS2) begin
			rd = hs2_q;
		end else if (link.addr == cs_pkg::REG_WK_CTRL) begin
			rd = wkc_q;
		end else if (link.addr == cs_pkg::REG_WK_STAT1) begin
			rd = st1_q;
		end else if (link.addr == cs_pkg::REG_WK_STAT2) begin
			rd = st2_q;
		end else if (link.addr == cs_pkg::REG_WK_LVL) begin
			rd = {5'h00, lvl_q};
		end else if (link.addr == cs_pkg::REG_MODE) begin
			rd = {5'h00, mode_q};
		end else if (link.addr == cs_pkg::REG_FAIL) begin
			rd = {7'h00, fail_q};
		end else begin
			rd = 8'h00;
		end
	end

	always_ff @(posedge I_MCLK) begin
		if (!I_RST_N) begin
			link.ack <= 1'b0;
			link.rdata <= 8'h00;
		end else begin
			link.ack <= link.req;
			link.rdata <= link.req ? rd : link.rdata;
		end
	end
endmodule

// ==== hw/cs_host.sv ====
// controller end: APB registers that issue link accesses to the device
`timescale 1ns/10ps
module cs_host (
	input wire logic I_MCLK,
	input wire logic I_RST_N,
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [7:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	output logic [31:0] O_PRDATA,
	output logic O_PREADY,
	output logic O_PSLVERR,
	cs_link_if.host link
);
	logic busy_q;
	logic [7:0] rdata_q;
	logic cmdw;

	assign O_PREADY = 1'b1;
	assign O_PSLVERR = 1'b0;
	// ordering of configuration steps is left to software; a command
	// written while busy is dropped, so software polls busy first
	assign cmdw = I_PSEL && I_PENABLE && I_PWRITE && I_PADDR == cs_pkg::APB_CMD && !busy_q;

	always_ff @(posedge I_MCLK) begin
		if (!I_RST_N) begin
			link.req <= 1'b0;
			link.we <= 1'b0;
			link.addr <= 4'h0;
			link.wdata <= 8'h00;
		end else begin
			link.req <= cmdw;
			if (cmdw) begin
				link.we <= I_PWDATA[cs_pkg::CMD_WE_BIT];
				link.addr <= I_PWDATA[cs_pkg::CMD_ADDR_LSB +: 4];
				link.wdata <= I_PWDATA[cs_pkg::CMD_DATA_LSB +: 8];
			end
		end
	end

	always_ff @(posedge I_MCLK) begin
		if (!I_RST_N) begin
			busy_q <= 1'b0;
			rdata_q <= 8'h00;
		end else begin
			busy_q <= cmdw || (busy_q && !link.ack);
			rdata_q <= link.ack ? link.rdata : rdata_q;
		end
	end

	// read data captured in the setup cycle, stable through access
	always_ff @(posedge I_MCLK) begin
		if (!I_RST_N) begin
			O_PRDATA <= 32'h0000_0000;
		end else if (I_PSEL && !I_PENABLE) begin
			if (I_PADDR == cs_pkg::APB_STAT) begin
				O_PRDATA <= {16'h0000, rdata_q, 6'h00, !link.int_n, busy_q};
			end else begin
				O_PRDATA <= 32'h0000_0000;
			end
		end
	end
endmodule

// ==== verification/cs_link_sva.sv ====
// link checker for the cyclic sense host and device ends
`timescale 1ns/10ps
module cs_link_sva (
	input wire logic I_MCLK,
	input wire logic I_RST_N,
	input wire logic i_req,
	input wire logic i_we,
	input wire logic [3:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_ack,
	input wire logic [7:0] i_rdata,
	input wire logic i_int_n
);
	logic fail_exp_q;
	logic over_wr;
	logic rd_fail;
	default clocking cb @(posedge I_MCLK); endclocking
	default disable iff (!I_RST_N);
	// only 20 ms on period code 0 is tracked; the same overrun on code 7, also 10 ms, goes unchecked
	assign over_wr = i_req && i_we
		&& (i_addr == cs_pkg::REG_TIMER1 || i_addr == cs_pkg::REG_TIMER2)
		&& i_wdata[6:4] == 3'h5 && i_wdata[2:0] == 3'h0;
	assign rd_fail = i_req && !i_we && i_addr == cs_pkg::REG_FAIL;
	always_ff @(posedge I_MCLK) begin
		if (!I_RST_N) begin
			fail_exp_q <= 1'b0;
		end else if (over_wr) begin
			fail_exp_q <= 1'b1;
		end else if (i_req && i_we && i_addr == cs_pkg::REG_FAIL && i_wdata[0]) begin
			fail_exp_q <= 1'b0;
		end
	end
	a_ack_follows_req: assert property (i_req |=> i_ack)
		else $error("link ack missing after request");
	a_ack_has_cause: assert property (i_ack |-> $past(i_req))
		else $error("link ack without request");
	a_req_single_pulse: assert property (i_req |=> !i_req)
		else $error("link request longer than one cycle");
	a_rdata_holds_idle: assert property (!i_ack |-> $stable(i_rdata))
		else $error("read data changed without ack");
	a_unmapped_read_zero: assert property (i_req && !i_we && i_addr > 4'h9 |=> i_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_mode_read_legal: assert property (i_req && !i_we && i_addr == cs_pkg::REG_MODE
		|=> i_rdata <= 8'h04)
		else $error("mode readback outside mode codes");
	a_status_one_width: assert property (i_req && !i_we && i_addr == cs_pkg::REG_WK_STAT1
		|=> i_rdata[7:3] == 5'h00)
		else $error("wake status one has stray bits");
	a_status_two_width: assert property (i_req && !i_we && i_addr == cs_pkg::REG_WK_STAT2
		|=> i_rdata[7:2] == 6'h00)
		else $error("wake status two has stray bits");
	a_level_width: assert property (i_req && !i_we && i_addr == cs_pkg::REG_WK_LVL
		|=> i_rdata[7:3] == 5'h00)
		else $error("level status has stray bits");
	a_fail_flag_set: assert property (rd_fail && fail_exp_q |=> i_rdata[0])
		else $error("serial fail not set after on-time overrun");
	c_sleep_req: cover property (i_req && i_we && i_addr == cs_pkg::REG_MODE && i_wdata == 8'h02);
	c_int_fell: cover property ($fell(i_int_n));
	c_fail_read: cover property (rd_fail ##1 i_rdata[0]);
endmodule

// ==== verification/tb.sv ====
// testbench: host and device joined by the link, driven over APB
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; \
	$display("mismatch %s expected %h seen %h", nm, (e), (g)); end end
module tb;
	logic clk, rst_n, psel, penable, pwrite, pready, pslverr, fs, supply, rstn_out;
	logic [7:0] paddr, rd;
	logic [31:0] pwdata, prdata, r;
	logic [2:0] wake, fault, hs_on, mode;
	int failures, checks_done;
	cs_link_if lnk();
	cs_host i_cs_host(.I_MCLK(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(penable),
		.I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
		.O_PREADY(pready), .O_PSLVERR(pslverr), .link(lnk));
	// one clock per tick keeps a 10 ms period at 10000 cycles
	cs_device #(.TICK_CYCLES(1)) i_cs_device(.I_MCLK(clk), .I_RST_N(rst_n), .I_WAKE_IN(wake),
		.I_HS_FAULT(fault), .I_FAIL_SAFE(fs), .O_HS_ON(hs_on), .O_MAIN_SUPPLY_EN(supply),
		.O_RESET_N(rstn_out), .O_MODE(mode), .link(lnk));
	cs_link_sva i_cs_link_sva(.I_MCLK(clk), .I_RST_N(rst_n), .i_req(lnk.req), .i_we(lnk.we),
		.i_addr(lnk.addr), .i_wdata(lnk.wdata), .i_ack(lnk.ack), .i_rdata(lnk.rdata),
		.i_int_n(lnk.int_n));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic dev(input logic wr, input logic [3:0] idx, input logic [7:0] d);
		int n;
		n = 0;
		apb(1'b1, cs_pkg::APB_CMD, {15'h0, wr, d, 4'h0, idx});
		repeat (3) @(posedge clk);
		do begin
			apb(1'b0, cs_pkg::APB_STAT, 32'h0);
			n++;
		end while (r[0] !== 1'b0 && n < 50);
		`CHK("link_busy", 1'b0, r[0])
		rd = r[15:8];
	endtask
	task automatic wait_mode(input logic [2:0] e, input int lim);
		int n;
		n = 0;
		while (mode !== e && n < lim) begin
			@(posedge clk);
			n++;
		end
		`CHK("mode", e, mode)
	endtask
	task automatic wait_sig(input int sel, input logic v, input int lim);
		int n;
		n = 0;
		while ((sel ? lnk.int_n : hs_on[0]) !== v && n < lim) begin
			@(posedge clk);
			n++;
		end
		`CHK("wait_sig", v, sel ? lnk.int_n : hs_on[0])
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic t_reset();
		`CHK("reset_out", 1'b1, rstn_out)
		`CHK("mode", cs_pkg::MODE_NORMAL, mode)
		dev(1'b0, cs_pkg::REG_TIMER1, 8'h00);
		`CHK("timer1", cs_pkg::REG_RESET, rd)
		dev(1'b0, cs_pkg::REG_MODE, 8'h00);
		`CHK("mode_reg", 8'h00, rd)
		dev(1'b0, 4'hc, 8'h00);
		`CHK("unmapped_dev", 8'h00, rd)
		apb(1'b0, 8'h10, 32'h0);
		`CHK("unmapped_apb", 32'h0, r)
		`CHK("pslverr", 1'b0, pslverr)
	endtask
	task automatic t_serial_fail();
		dev(1'b1, cs_pkg::REG_TIMER2, 8'h50);
		dev(1'b0, cs_pkg::REG_FAIL, 8'h00);
		`CHK("fail_set", 8'h01, rd)
		dev(1'b1, cs_pkg::REG_FAIL, 8'h01);
		// every period with the shortest on-time, every on-time with the longest period
		for (int p = 0; p < 7; p++) dev(1'b1, cs_pkg::REG_TIMER2, {4'h1, 1'b0, 3'(p)});
		for (int o = 1; o < 6; o++) dev(1'b1, cs_pkg::REG_TIMER2, {1'b0, 3'(o), 4'h6});
		dev(1'b1, cs_pkg::REG_TIMER2, 8'h41);
		// equal on-time and period is not an overrun
		dev(1'b1, cs_pkg::REG_TIMER2, 8'h40);
		dev(1'b0, cs_pkg::REG_FAIL, 8'h00);
		`CHK("fail_clear", 8'h00, rd)
		dev(1'b1, cs_pkg::REG_TIMER2, 8'h00);
	endtask
	task automatic t_cyclic_sense();
		dev(1'b1, cs_pkg::REG_TIMER1, {1'b0, cs_pkg::ON_OFF_HIGH, 4'h0});
		dev(1'b1, cs_pkg::REG_HS1, 8'h01);
		repeat (4) @(posedge clk);
		`CHK("hs_off_high", 3'b001, hs_on)
		dev(1'b1, cs_pkg::REG_TIMER1, 8'h00);
		repeat (4) @(posedge clk);
		`CHK("hs_off_low", 3'b000, hs_on)
		dev(1'b1, cs_pkg::REG_HS2, 8'h03);
		repeat (4) @(posedge clk);
		`CHK("hs_forced_on", 3'b100, hs_on)
		dev(1'b1, cs_pkg::REG_HS2, 8'h00);
		dev(1'b1, cs_pkg::REG_WK_CTRL, 8'h04);
		dev(1'b1, cs_pkg::REG_TIMER1, 8'h10);
		wait_sig(0, 1'b1, 300);
		wait_sig(0, 1'b0, 300);
		repeat (40) @(posedge clk);
		wake <= 3'b001;
		// a change outside the on-time stays unseen until the next window
		repeat (9000) @(posedge clk);
		`CHK("int_early", 1'b1, lnk.int_n)
		wait_sig(1, 1'b0, 2000);
		apb(1'b0, cs_pkg::APB_STAT, 32'h0);
		`CHK("stat_int", 1'b1, r[cs_pkg::STAT_INT_BIT])
		dev(1'b0, cs_pkg::REG_WK_STAT1, 8'h00);
		`CHK("wake_event", 8'h01, rd)
		dev(1'b0, cs_pkg::REG_WK_LVL, 8'h00);
		`CHK("level", 1'b1, rd[0])
	endtask
	task automatic t_sleep();
		dev(1'b1, cs_pkg::REG_MODE, 8'h02);
		wait_mode(cs_pkg::MODE_RESTART, 20);
		`CHK("reset_low", 1'b0, rstn_out)
		wait_mode(cs_pkg::MODE_NORMAL, 300);
		dev(1'b0, cs_pkg::REG_WK_STAT1, 8'h00);
		`CHK("wake_source", 8'h01, rd)
		dev(1'b1, cs_pkg::REG_WK_STAT1, 8'h07);
		`CHK("int_clear", 1'b1, lnk.int_n)
		dev(1'b1, cs_pkg::REG_MODE, 8'h02);
		wait_mode(cs_pkg::MODE_SLEEP, 20);
		`CHK("supply_sleep", 1'b0, supply)
		wake <= 3'b000;
		wait_mode(cs_pkg::MODE_RESTART, 21000);
		`CHK("supply_up", 1'b1, supply)
		wait_mode(cs_pkg::MODE_NORMAL, 300);
		dev(1'b0, cs_pkg::REG_WK_STAT1, 8'h00);
		`CHK("sleep_event", 8'h01, rd)
	endtask
	task automatic t_cyclic_wake();
		dev(1'b1, cs_pkg::REG_TIMER1, 8'h00);
		dev(1'b1, cs_pkg::REG_WK_CTRL, 8'h01);
		fault <= 3'b001;
		repeat (40) @(posedge clk);
		dev(1'b1, cs_pkg::REG_WK_STAT1, 8'h07);
		dev(1'b1, cs_pkg::REG_WK_STAT2, 8'h03);
		dev(1'b1, cs_pkg::REG_TIMER1, 8'h10);
		repeat (5000) @(posedge clk);
		dev(1'b0, cs_pkg::REG_WK_STAT2, 8'h00);
		`CHK("first_start", 8'h00, rd)
		wait_sig(1, 1'b0, 11000);
		dev(1'b0, cs_pkg::REG_WK_STAT2, 8'h00);
		`CHK("timer_wake", 8'h01, rd)
		// fault gone, but the latch keeps the switch off inside the on-time
		fault <= 3'b000;
		repeat (4) @(posedge clk);
		`CHK("hs_fault_off", 3'b000, hs_on)
	endtask
	task automatic t_failsafe();
		fault <= 3'b000;
		fs <= 1'b1;
		wait_mode(cs_pkg::MODE_FAILSAFE, 20);
		`CHK("hs_failsafe", 3'b000, hs_on)
		`CHK("supply_failsafe", 1'b0, supply)
	endtask
	initial begin
		failures = 0;
		checks_done = 0;
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		wake = 3'b000;
		fault = 3'b000;
		fs = 1'b0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		t_reset();
		t_serial_fail();
		t_cyclic_sense();
		t_sleep();
		t_cyclic_wake();
		t_failsafe();
		end_of_test();
	end
	initial begin
		repeat (100000) @(posedge clk);
		failures++;
		end_of_test();
	end
endmodule
